// ==== can_rx_map.svh ====
`ifndef CAN_RX_MAP_SVH
`define CAN_RX_MAP_SVH

// message buffer geometry
`define MSG_BYTES 13
`define TX_BUFS 3

// register offsets (byte addresses on the plain register port)
`define OFS_FG_BASE 8'h00
`define OFS_RX_FLAG 8'h10
`define OFS_RX_IEN 8'h11
`define OFS_CTRL 8'h12
`define OFS_TX_FLAG 8'h13
`define OFS_PORT_DATA 8'h14
`define OFS_PORT_DIR 8'h15
`define OFS_TX_BASE 8'h20
`define TX_STRIDE 8'h10

// field positions
`define BIT_RX_FULL 0
`define BIT_OVERRUN 1
`define BIT_RX_IE 0
`define BIT_OVR_IE 1
`define BIT_LOOPBACK 0

// reset values
`define RST_TXE 3'h7
`define RST_BYTE 8'h00

`endif

// ==== can_rx_pkg.sv ====
package can_rx_pkg;

    // one cycle of activity reported by the bit-level frame engine
    typedef struct packed {
        logic frame_start; // first bit of a new frame seen
        logic byte_valid; // byte_data belongs at byte_idx
        logic [3:0] byte_idx;
        logic [7:0] byte_data;
        logic frame_ok; // frame ended correctly, pulse
        logic filter_hit; // acceptance result, valid with frame_ok
        logic arb_lost; // node lost arbitration, pulse
    } rx_evt_t;

    // receive queue occupancy, one-hot
    typedef enum logic [2:0] {
        Q_EMPTY = 3'b001,
        Q_ONE = 3'b010,
        Q_TWO = 3'b100
    } rxq_state_t;

    typedef logic [7:0] msg_byte_t;

endpackage

// ==== tx_buffer_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.svh"

module tx_buffer_bank
    import can_rx_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic wr_en, // software byte write
    input wire logic [1:0] wr_buf, // buffer selected by software
    input wire logic [3:0] wr_idx, // byte index in buffer
    input wire msg_byte_t wr_data, // byte to store
    input wire logic [2:0] txe_clr, // write-one mask on empty flags
    input wire logic [1:0] rd_buf, // buffer read (software or engine)
    input wire logic [3:0] rd_idx, // byte index read
    output msg_byte_t rd_byte, // combinational read byte
    input wire logic tx_done, // engine finished a buffer, pulse
    input wire logic [1:0] tx_done_buf, // which buffer finished
    output logic [2:0] txe, // empty flags, registered
    output logic [2:0] tx_pending // buffers queued for sending
);

    msg_byte_t mem_ff [`TX_BUFS][`MSG_BYTES];
    msg_byte_t nxt_mem [`TX_BUFS][`MSG_BYTES];
    logic [2:0] txe_ff;
    logic [2:0] nxt_txe;

    // a buffer only accepts data while it is empty, so a queued frame
    // cannot be torn by a late write
    always_comb begin
        nxt_mem = mem_ff;
        nxt_txe = txe_ff & ~txe_clr;
        if (wr_en && wr_buf < 2'd3 && wr_idx < 4'd13 && txe_ff[wr_buf]) begin
            nxt_mem[wr_buf][wr_idx] = wr_data;
        end
        // completion sets the flag back, winning over a clear
        if (tx_done && tx_done_buf < 2'd3) begin
            nxt_txe[tx_done_buf] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txe_ff <= `RST_TXE;
            for (int b = 0; b < `TX_BUFS; b++) begin
                for (int i = 0; i < `MSG_BYTES; i++) begin
                    mem_ff[b][i] <= `RST_BYTE;
                end
            end
        end else begin
            txe_ff <= nxt_txe;
            mem_ff <= nxt_mem;
        end
    end

    assign txe = txe_ff;
    assign tx_pending = ~txe_ff;
    assign rd_byte = (rd_buf < 2'd3 && rd_idx < 4'd13) ?
        mem_ff[rd_buf][rd_idx] : `RST_BYTE;

endmodule
`default_nettype wire

// ==== can_receive_double_buffer.sv ====
// Overview of operation
// - transmit pin low means dominant, high means recessive
// - receive pin is port bit 0, transmit bit 1; rest port registers
// - three transmit buffers so frames can queue back to back
// - receive queue: hidden background buffer then readable foreground
// - each receive buffer holds 13 bytes
// - receive-full set when foreground holds an accepted good frame
// - every frame lands in background regardless of filter result, unless the queue is full
// - accepted frame copied to foreground and flag set only if clear
// - next frame accepted right after interframe space
// - own frame captured in background, no foreground, irq or ack
// - loop-back treats own frames like any incoming frame
// - lost arbitration turns the node into an ordinary receiver
// - third accepted frame discarded, overrun flagged, error irq
// - with both buffers full, transmit continues, input discarded
// - receive irq only when unmasked; flag also pollable
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.svh"

module can_receive_double_buffer
    import can_rx_pkg::*;
(
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic can_receive_pin, // bus level from transceiver
    output logic can_transmit_pin, // bus level to transceiver
    input wire logic [5:0] port_in, // levels of port bits 7..2
    output logic [5:0] port_out, // drive values of port bits 7..2
    output logic [5:0] port_oe, // drive enables of port bits 7..2
    input wire rx_evt_t rx_evt, // frame engine receive activity
    input wire logic tx_active, // engine sends the current frame
    input wire logic tx_dominant, // engine wants a dominant bit
    output logic engine_rx_bit, // bus level seen by the engine
    output logic ack_enable, // engine may acknowledge this frame
    output logic loopback, // loop-back mode selected
    output logic [2:0] tx_pending, // transmit buffers queued
    input wire logic [1:0] tx_rd_buf, // engine buffer select
    input wire logic [3:0] tx_rd_idx, // engine byte select
    output msg_byte_t tx_rd_byte, // byte for the engine
    input wire logic tx_done, // engine sent a buffer, pulse
    input wire logic [1:0] tx_done_buf, // buffer that was sent
    output logic rx_irq, // receive interrupt, level
    output logic err_irq // overrun interrupt, level
);

    // address decode helpers; in_fg serves the read path only, the others both read and write paths
    function automatic logic in_fg(input logic [7:0] a);
        return a < (`OFS_FG_BASE + 8'd13);
    endfunction

    function automatic logic in_tx(input logic [7:0] a);
        return a >= `OFS_TX_BASE && a < (`OFS_TX_BASE + 8'h30);
    endfunction

    function automatic logic [1:0] tx_buf_of(input logic [7:0] a);
        logic [7:0] d;
        d = a - `OFS_TX_BASE;
        return d[5:4];
    endfunction

    // receive storage
    msg_byte_t bg_ff [`MSG_BYTES];
    msg_byte_t nxt_bg [`MSG_BYTES];
    msg_byte_t fg_ff [`MSG_BYTES];
    msg_byte_t nxt_fg [`MSG_BYTES];
    rxq_state_t q_ff;
    rxq_state_t nxt_q;
    logic ovr_ff;
    logic nxt_ovr;
    logic own_ff;
    logic nxt_own;
    logic wr_bg_ff;
    logic nxt_wr_bg;

    // control registers
    logic rxie_ff;
    logic nxt_rxie;
    logic ovrie_ff;
    logic nxt_ovrie;
    logic lb_ff;
    logic nxt_lb;
    logic [5:0] pdata_ff;
    logic [5:0] nxt_pdata;
    logic [5:0] pdir_ff;
    logic [5:0] nxt_pdir;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    logic clr_full;
    logic clr_ovr;
    logic eligible;
    logic [2:0] txe_clr;
    logic [2:0] txe;
    logic tx_wr;
    msg_byte_t tx_sw_byte;
    logic [1:0] bank_rd_buf;
    logic [3:0] bank_rd_idx;
    logic [7:0] tx_off;

    tx_buffer_bank u_tx_bank (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(tx_wr),
        .wr_buf(tx_buf_of(reg_addr)),
        .wr_idx(tx_off[3:0]),
        .wr_data(reg_wdata),
        .txe_clr(txe_clr),
        .rd_buf(bank_rd_buf),
        .rd_idx(bank_rd_idx),
        .rd_byte(tx_sw_byte),
        .tx_done(tx_done),
        .tx_done_buf(tx_done_buf),
        .txe(txe),
        .tx_pending(tx_pending)
    );

    // the engine owns the bank read port while it sends; a software read
    // of a queued buffer in that window returns the engine's byte
    assign tx_off = reg_addr - `OFS_TX_BASE;
    assign bank_rd_buf = tx_active ? tx_rd_buf : tx_buf_of(reg_addr);
    assign bank_rd_idx = tx_active ? tx_rd_idx : tx_off[3:0];
    assign tx_rd_byte = tx_sw_byte;
    assign tx_wr = reg_we && in_tx(reg_addr);
    assign txe_clr = (reg_we && reg_addr == `OFS_TX_FLAG) ?
        reg_wdata[2:0] : 3'h0;

    // write-one clears of the receiver flag register
    assign clr_full = reg_we && reg_addr == `OFS_RX_FLAG &&
        reg_wdata[`BIT_RX_FULL];
    assign clr_ovr = reg_we && reg_addr == `OFS_RX_FLAG &&
        reg_wdata[`BIT_OVERRUN];

    // own frames count only in loop-back
    assign eligible = rx_evt.frame_ok && rx_evt.filter_hit &&
        (!own_ff || lb_ff);

    // track whether the frame on the bus is our own
    always_comb begin
        nxt_own = own_ff;
        if (rx_evt.frame_start) begin
            nxt_own = tx_active;
        end
        if (rx_evt.arb_lost) begin
            nxt_own = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            own_ff <= 1'b0;
        end else begin
            own_ff <= nxt_own;
        end
    end

    // receive queue: background fill, transfer, overrun
    always_comb begin
        nxt_bg = bg_ff;
        nxt_fg = fg_ff;
        nxt_q = q_ff;
        nxt_ovr = ovr_ff & ~clr_ovr;
        nxt_wr_bg = wr_bg_ff;
        // background reopens at each new frame unless the queue is full
        if (rx_evt.frame_start) begin
            nxt_wr_bg = (q_ff != Q_TWO);
        end
        if (rx_evt.byte_valid && wr_bg_ff && q_ff != Q_TWO &&
            rx_evt.byte_idx < 4'd13) begin
            nxt_bg[rx_evt.byte_idx] = rx_evt.byte_data;
        end
        case (q_ff)
            Q_EMPTY: begin
                if (eligible) begin
                    nxt_fg = bg_ff;
                    nxt_q = Q_ONE;
                end
            end
            Q_ONE: begin
                if (clr_full && eligible) begin
                    nxt_fg = bg_ff;
                end else if (clr_full) begin
                    nxt_q = Q_EMPTY;
                end else if (eligible) begin
                    nxt_q = Q_TWO;
                end
            end
            Q_TWO: begin
                // pending frame moves up, flag stays set
                if (clr_full) begin
                    nxt_fg = bg_ff;
                    nxt_q = Q_ONE;
                end
                if (eligible) begin
                    nxt_ovr = 1'b1;
                end
            end
            default: begin
                nxt_q = Q_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q_ff <= Q_EMPTY;
            ovr_ff <= 1'b0;
            wr_bg_ff <= 1'b0;
            for (int i = 0; i < `MSG_BYTES; i++) begin
                bg_ff[i] <= `RST_BYTE;
                fg_ff[i] <= `RST_BYTE;
            end
        end else begin
            q_ff <= nxt_q;
            ovr_ff <= nxt_ovr;
            wr_bg_ff <= nxt_wr_bg;
            bg_ff <= nxt_bg;
            fg_ff <= nxt_fg;
        end
    end

    // control register writes
    always_comb begin
        nxt_rxie = rxie_ff;
        nxt_ovrie = ovrie_ff;
        nxt_lb = lb_ff;
        nxt_pdata = pdata_ff;
        nxt_pdir = pdir_ff;
        if (reg_we) begin
            case (reg_addr)
                `OFS_RX_IEN: begin
                    nxt_rxie = reg_wdata[`BIT_RX_IE];
                    nxt_ovrie = reg_wdata[`BIT_OVR_IE];
                end
                `OFS_CTRL: begin
                    nxt_lb = reg_wdata[`BIT_LOOPBACK];
                end
                `OFS_PORT_DATA: begin
                    nxt_pdata = reg_wdata[7:2];
                end
                `OFS_PORT_DIR: begin
                    nxt_pdir = reg_wdata[7:2];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxie_ff <= 1'b0;
            ovrie_ff <= 1'b0;
            lb_ff <= 1'b0;
            pdata_ff <= 6'h00;
            pdir_ff <= 6'h00;
        end else begin
            rxie_ff <= nxt_rxie;
            ovrie_ff <= nxt_ovrie;
            lb_ff <= nxt_lb;
            pdata_ff <= nxt_pdata;
            pdir_ff <= nxt_pdir;
        end
    end

    // read mux; unmapped addresses return zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_re) begin
            if (in_fg(reg_addr)) begin
                nxt_rdata = fg_ff[reg_addr[3:0]];
            end else if (in_tx(reg_addr)) begin
                nxt_rdata = (tx_off[3:0] < 4'd13) ? tx_sw_byte : 8'h00;
            end else begin
                case (reg_addr)
                    `OFS_RX_FLAG: nxt_rdata = {6'h00, ovr_ff, q_ff != Q_EMPTY};
                    `OFS_RX_IEN: nxt_rdata = {6'h00, ovrie_ff, rxie_ff};
                    `OFS_CTRL: nxt_rdata = {7'h00, lb_ff};
                    `OFS_TX_FLAG: nxt_rdata = {5'h00, txe};
                    // pin 0 input, pin 1 output level
                    `OFS_PORT_DATA: nxt_rdata = {
                        (pdir_ff & pdata_ff) | (~pdir_ff & port_in),
                        can_transmit_pin, can_receive_pin};
                    `OFS_PORT_DIR: nxt_rdata = {pdir_ff, 2'b10};
                    default: nxt_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // pins; loop-back keeps the bus recessive and feeds tx back internally
    // low is dominant
    assign can_transmit_pin = lb_ff ? 1'b1 : ~tx_dominant;
    assign engine_rx_bit = lb_ff ? ~tx_dominant : can_receive_pin;
    assign port_out = pdata_ff;
    assign port_oe = pdir_ff;
    assign loopback = lb_ff;

    // full queue still transmits, never acknowledges
    assign ack_enable = !(own_ff && !lb_ff) && q_ff != Q_TWO;

    assign rx_irq = rxie_ff && q_ff != Q_EMPTY;
    assign err_irq = ovrie_ff && ovr_ff;

endmodule
`default_nettype wire

// ==== can_transceiver_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module can_transceiver_model #(
    parameter int LAG = 3
) (
    input wire logic clk_sys, // system clock
    input wire logic txd, // level from the controller
    input wire logic remote_dom, // another node drives dominant
    output logic rxd // bus level back to the controller
);
    logic [LAG-1:0] dly_ff = '1;

    // wired-and bus: any dominant driver wins, idle bus is recessive
    always_ff @(posedge clk_sys) begin
        dly_ff <= {dly_ff[LAG-2:0], txd & ~remote_dom};
    end

    // a few cycles of round trip, as a real transceiver loop has
    assign rxd = dly_ff[LAG-1];
endmodule

`default_nettype wire

// ==== can_rx_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.svh"

module can_rx_checker
    import can_rx_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic can_receive_pin, // bus level in
    input wire logic can_transmit_pin, // bus level out
    input wire logic [5:0] port_oe, // port drive enables
    input wire rx_evt_t rx_evt, // receive activity
    input wire logic tx_active, // engine sending
    input wire logic tx_dominant, // engine wants dominant
    input wire logic engine_rx_bit, // level seen by engine
    input wire logic ack_enable, // acknowledge allowed
    input wire logic loopback, // loop-back mode
    input wire logic [2:0] tx_pending, // queued buffers
    input wire logic tx_done, // buffer sent
    input wire logic [1:0] tx_done_buf, // which buffer
    input wire logic rx_irq, // receive interrupt
    input wire logic err_irq // overrun interrupt
);
    logic cause;

    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // interrupts may only rise after a good frame or a register write
    assign cause = (rx_evt.frame_ok & rx_evt.filter_hit) | reg_we;

    // own frame starting outside loop-back
    sequence own_start_s;
        rx_evt.frame_start && tx_active && !loopback;
    endsequence
    sequence port_read_s;
        reg_re && reg_addr == `OFS_PORT_DATA;
    endsequence

    tx_level_a: assert property (
        can_transmit_pin == (loopback | ~tx_dominant))
        else $error("transmit pin level wrong");
    loop_path_a: assert property (
        engine_rx_bit == (loopback ? ~tx_dominant : can_receive_pin))
        else $error("engine receive level wrong");
    own_ack_a: assert property (
        own_start_s |=> !ack_enable)
        else $error("own frame still acknowledged");
    irq_cause_a: assert property (
        $rose(rx_irq) |-> $past(cause))
        else $error("receive interrupt without cause");
    err_cause_a: assert property (
        $rose(err_irq) |-> $past(cause))
        else $error("overrun interrupt without cause");
    irq_mask_a: assert property (
        reg_we && reg_addr == `OFS_RX_IEN && !reg_wdata[0] |=> !rx_irq)
        else $error("masked receive interrupt raised");
    pin_read_a: assert property (
        port_read_s |=> reg_rdata[1:0] ==
            {$past(can_transmit_pin), $past(can_receive_pin)})
        else $error("pin bits misplaced in port read");
    dir_read_a: assert property (
        reg_re && reg_addr == `OFS_PORT_DIR |=> reg_rdata[1:0] == 2'b10)
        else $error("direction of pin bits wrong");
    port_oe_a: assert property (
        reg_we && reg_addr == `OFS_PORT_DIR
        |=> {port_oe, 2'b00} == ($past(reg_wdata) & 8'hfc))
        else $error("port enables not taken from write");
    tx_queue_a: assert property (
        reg_we && reg_addr == `OFS_TX_FLAG && !tx_done
        |=> ({5'h00, tx_pending} & $past(reg_wdata) & 8'h07)
            == ($past(reg_wdata) & 8'h07))
        else $error("cleared empty flag did not queue buffer");
    tx_done_a: assert property (
        tx_done && tx_done_buf != 2'd3 && !reg_we
        |=> !tx_pending[$past(tx_done_buf)])
        else $error("sent buffer still queued");
endmodule

bind can_receive_double_buffer can_rx_checker chk_u (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .can_receive_pin(can_receive_pin),
    .can_transmit_pin(can_transmit_pin), .port_oe(port_oe),
    .rx_evt(rx_evt), .tx_active(tx_active), .tx_dominant(tx_dominant),
    .engine_rx_bit(engine_rx_bit), .ack_enable(ack_enable),
    .loopback(loopback), .tx_pending(tx_pending), .tx_done(tx_done),
    .tx_done_buf(tx_done_buf), .rx_irq(rx_irq), .err_irq(err_irq)
);

`default_nettype wire

// ==== can_receive_double_buffer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "can_rx_map.svh"

module can_receive_double_buffer_tb
    import can_rx_pkg::*;
;
    typedef struct packed {
        logic we; // 1 write, 0 read and compare
        logic [7:0] addr;
        logic [7:0] data; // write data or expected read data
    } row_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_we = 1'b0, reg_re = 1'b0, remote_dom = 1'b0;
    logic can_receive_pin, can_transmit_pin, engine_rx_bit;
    logic ack_enable, loopback, rx_irq, err_irq;
    logic [5:0] port_out, port_oe;
    rx_evt_t rx_evt = '0;
    logic tx_active = 1'b0, tx_dominant = 1'b0, tx_done = 1'b0;
    logic [1:0] tx_rd_buf = 2'd0, tx_done_buf = 2'd0;
    logic [3:0] tx_rd_idx = 4'h0;
    logic [2:0] tx_pending;
    msg_byte_t tx_rd_byte;
    int err_total = 0, samples_checked = 0;
    row_t rows [19] = '{
        '{1'b0, 8'h10, 8'h00}, '{1'b0, 8'h11, 8'h00}, '{1'b0, 8'h12, 8'h00},
        '{1'b0, 8'h13, 8'h07}, '{1'b0, 8'h15, 8'h02}, '{1'b0, 8'h16, 8'h00},
        '{1'b0, 8'h0d, 8'h00}, '{1'b0, 8'h14, 8'hb7}, '{1'b1, 8'h15, 8'hff},
        '{1'b1, 8'h14, 8'h54}, '{1'b0, 8'h14, 8'h57}, '{1'b0, 8'h15, 8'hfe},
        '{1'b1, 8'h4c, 8'h5a}, '{1'b0, 8'h4c, 8'h5a}, '{1'b1, 8'h13, 8'h05},
        '{1'b1, 8'h4c, 8'h11}, '{1'b0, 8'h4c, 8'h5a}, '{1'b0, 8'h13, 8'h02},
        '{1'b1, 8'h15, 8'h00}};

    always #5 clk_sys = ~clk_sys;

    can_receive_double_buffer dut_u (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .can_receive_pin(can_receive_pin),
        .can_transmit_pin(can_transmit_pin), .port_in(6'h2d),
        .port_out(port_out), .port_oe(port_oe), .rx_evt(rx_evt),
        .tx_active(tx_active), .tx_dominant(tx_dominant),
        .engine_rx_bit(engine_rx_bit), .ack_enable(ack_enable),
        .loopback(loopback), .tx_pending(tx_pending),
        .tx_rd_buf(tx_rd_buf), .tx_rd_idx(tx_rd_idx),
        .tx_rd_byte(tx_rd_byte), .tx_done(tx_done),
        .tx_done_buf(tx_done_buf), .rx_irq(rx_irq), .err_irq(err_irq));

    can_transceiver_model #(.LAG(3)) xcvr_u (.clk_sys(clk_sys),
        .txd(can_transmit_pin), .remote_dom(remote_dom),
        .rxd(can_receive_pin));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // strobes drop after one edge, then one idle edge keeps drivers apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1;
        chk_byte(reg_rdata, exp);
        @(posedge clk_sys);
    endtask
    task automatic rd_fg(input logic [7:0] base);
        for (int i = 0; i < `MSG_BYTES; i++) begin
            rd(8'(i), base + 8'(i));
        end
    endtask
    // start, thirteen bytes, then the end-of-frame verdict
    task automatic frame(input logic [7:0] base, input logic hit,
                         input logic own, input logic lost);
        rx_evt.frame_start <= 1'b1;
        tx_active <= own;
        @(posedge clk_sys);
        rx_evt.frame_start <= 1'b0;
        rx_evt.byte_valid <= 1'b1;
        for (int i = 0; i < `MSG_BYTES; i++) begin
            rx_evt.byte_idx <= 4'(i);
            rx_evt.byte_data <= base + 8'(i);
            rx_evt.arb_lost <= lost && (i == 3);
            @(posedge clk_sys);
        end
        rx_evt.byte_valid <= 1'b0;
        rx_evt.arb_lost <= 1'b0;
        rx_evt.frame_ok <= 1'b1;
        rx_evt.filter_hit <= hit;
        tx_active <= 1'b0;
        @(posedge clk_sys);
        rx_evt <= '0;
        @(posedge clk_sys);
    endtask
    task automatic sent(input logic [1:0] b, input logic [7:0] exp);
        tx_done <= 1'b1;
        tx_done_buf <= b;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_byte({5'h00, tx_pending}, exp);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) begin
                wr(rows[i].addr, rows[i].data);
            end else begin
                rd(rows[i].addr, rows[i].data);
            end
        end
        tx_active <= 1'b1;
        tx_rd_buf <= 2'd2;
        tx_rd_idx <= 4'hc;
        @(posedge clk_sys);
        chk_byte(tx_rd_byte, 8'h5a);
        chk_byte({port_out, 2'b00}, 8'h54);
        tx_active <= 1'b0;
        sent(2'd2, 8'h01);
        $display("test registers done");
        // fill both stages, then overrun with the queue full
        wr(`OFS_RX_IEN, 8'h03);
        frame(8'ha0, 1'b1, 1'b0, 1'b0);
        chk_bit(rx_irq, 1'b1);
        rd(`OFS_RX_FLAG, 8'h01);
        rd_fg(8'ha0);
        frame(8'hb0, 1'b1, 1'b0, 1'b0);
        rd_fg(8'ha0);
        frame(8'hc0, 1'b1, 1'b0, 1'b0);
        rd(`OFS_RX_FLAG, 8'h03);
        chk_bit(err_irq, 1'b1);
        chk_bit(ack_enable, 1'b0);
        sent(2'd0, 8'h00);
        rd_fg(8'ha0);
        wr(`OFS_RX_FLAG, 8'h01);
        rd(`OFS_RX_FLAG, 8'h03);
        rd_fg(8'hb0);
        wr(`OFS_RX_FLAG, 8'h02);
        rd(`OFS_RX_FLAG, 8'h01);
        wr(`OFS_RX_FLAG, 8'h01);
        chk_bit(rx_irq, 1'b0);
        rd(`OFS_RX_FLAG, 8'h00);
        $display("test queue done");
        frame(8'hd0, 1'b0, 1'b0, 1'b0);
        frame(8'he0, 1'b1, 1'b1, 1'b0);
        rd(`OFS_RX_FLAG, 8'h00);
        frame(8'hf0, 1'b1, 1'b1, 1'b1);
        rd_fg(8'hf0);
        wr(`OFS_RX_FLAG, 8'h01);
        wr(`OFS_CTRL, 8'h01);
        tx_dominant <= 1'b1;
        frame(8'h70, 1'b1, 1'b1, 1'b0);
        chk_bit(can_transmit_pin, 1'b1);
        chk_bit(engine_rx_bit, 1'b0);
        chk_bit(loopback, 1'b1);
        rd(`OFS_RX_FLAG, 8'h01);
        rd_fg(8'h70);
        wr(`OFS_RX_FLAG, 8'h01);
        wr(`OFS_CTRL, 8'h00);
        #1;
        chk_bit(can_transmit_pin, 1'b0);
        @(posedge clk_sys);
        tx_dominant <= 1'b0;
        remote_dom <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(`OFS_PORT_DATA, 8'hb6);
        remote_dom <= 1'b0;
        $display("test own frames and pins done");
        wr(`OFS_RX_IEN, 8'h00);
        frame(8'h90, 1'b1, 1'b0, 1'b0);
        chk_bit(rx_irq, 1'b0);
        rd(`OFS_RX_FLAG, 8'h01);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rd(`OFS_RX_FLAG, 8'h00);
        rd(`OFS_TX_FLAG, 8'h07);
        $display("test mask and reset done");
        summarize();
    end
endmodule

`default_nettype wire
